// ---- rpsc_pkg.sv ----
// Shared constants for the ROM page strap configuration loader.
// Assumes a single 250 MHz clock domain and an active-low asynchronous reset.
package rpsc_pkg;
	localparam int unsigned STRAP_W = 3;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [6:0] I2C_ADDR_BASE = 7'h64;
	localparam logic [1:0] I2C_ADDR_LSB_FORCED = 2'h0;
	localparam logic [1:0] DRV_CFG_RESET = 2'h0;
	localparam int unsigned CLK_PERIOD_NS = 4;
	localparam int unsigned SETTLE_NS = 16;
	localparam int unsigned SETTLE_CYC = (SETTLE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	typedef enum logic [1:0] {RPSC_IN_RESET, RPSC_CAPTURE, RPSC_RUN}
		rpsc_state_t;
endpackage

// ---- rpsc_strap_config.sv ----
// Power-on strap capture, ROM page select, I2C address and status pin roles.
// Assumes strap and status pin levels are synchronous to clock and that the
// board holds the straps steady around the release of reset_n.
//
// Operation
// - Straps sampled at power-on reset pick the ROM page to load.
// - Strap value n selects ROM page n, 0 to 7, zero by default.
// - After reset, in controlled oscillator mode strap pin two is the frequency increment input.
// - After reset, status pin one may be the frequency decrement input.
// - In ROM plus I2C mode the two low I2C address bits are zero.
// - Each status output selects open-drain or push-pull drive.
module rpsc_strap_config #(
	parameter int unsigned SETTLE_CYCLES = rpsc_pkg::SETTLE_CYC
)(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [2:0] strap_pins,
	input wire logic startup_mode_select,
	input wire logic controlled_osc_mode,
	input wire logic [1:0] drv_open_drain,
	input wire logic decrement_enable,
	input wire logic [1:0] status_value,
	input wire logic [1:0] status_pin_in,
	output logic [2:0] rom_page,
	output logic config_done,
	output logic [6:0] i2c_target_addr,
	output logic freq_increment_input,
	output logic freq_decrement_input,
	output logic status_out_zero,
	output logic status_out_zero_oe,
	output logic status_out_one,
	output logic status_out_one_oe
);
	rpsc_pkg::rpsc_state_t state_r;
	logic [7:0] settle_r;
	logic [2:0] page_r;
	logic done_r;
	logic strap_pin_two;
	logic dec_active;

	assign strap_pin_two = strap_pins[2];
	assign dec_active = done_r && controlled_osc_mode && decrement_enable;

	// ----------------------------------------------------------------
	// Strap capture sequence
	// ----------------------------------------------------------------
	// Capture happens a few cycles after release rather than under the
	// asynchronous reset, so no flop ever loads a port value at reset.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_r <= rpsc_pkg::RPSC_IN_RESET;
			settle_r <= 8'h00;
		end
		else
		begin
			case (state_r)
				rpsc_pkg::RPSC_IN_RESET:
				begin
					if (settle_r >= 8'(SETTLE_CYCLES - 1))
						state_r <= rpsc_pkg::RPSC_CAPTURE;
					else
						settle_r <= settle_r + 8'h01;
				end
				rpsc_pkg::RPSC_CAPTURE:
					state_r <= rpsc_pkg::RPSC_RUN;
				rpsc_pkg::RPSC_RUN:
					state_r <= rpsc_pkg::RPSC_RUN;
				default:
					state_r <= rpsc_pkg::RPSC_IN_RESET;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			page_r <= rpsc_pkg::PAGE_RESET;
			done_r <= 1'b0;
		end
		else if (state_r == rpsc_pkg::RPSC_CAPTURE)
		begin
			page_r <= strap_pins;
			done_r <= 1'b1;
		end
	end

	assign rom_page = page_r;
	assign config_done = done_r;

	// ----------------------------------------------------------------
	// I2C address
	// ----------------------------------------------------------------
	// address low bits
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			i2c_target_addr <= rpsc_pkg::I2C_ADDR_BASE;
		else if (startup_mode_select)
			i2c_target_addr <= {rpsc_pkg::I2C_ADDR_BASE[6:2],
				rpsc_pkg::I2C_ADDR_LSB_FORCED};
		else
			i2c_target_addr <= rpsc_pkg::I2C_ADDR_BASE;
	end

	// ----------------------------------------------------------------
	// Second pin roles after reset
	// ----------------------------------------------------------------
	// increment input role
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			freq_increment_input <= 1'b0;
		else
			freq_increment_input <= done_r && controlled_osc_mode
				&& strap_pin_two;
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			freq_decrement_input <= 1'b0;
		else
			freq_decrement_input <= dec_active && status_pin_in[1];
	end

	// ----------------------------------------------------------------
	// Status drivers
	// ----------------------------------------------------------------
	// driver type select
	// Open-drain only pulls low; a high level needs the board pullup.
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_out_zero <= 1'b0;
			status_out_zero_oe <= 1'b0;
		end
		else
		begin
			status_out_zero <= drv_open_drain[0] ? 1'b0 : status_value[0];
			status_out_zero_oe <= done_r && (!drv_open_drain[0]
				|| !status_value[0]);
		end
	end

	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
		begin
			status_out_one <= 1'b0;
			status_out_one_oe <= 1'b0;
		end
		else
		begin
			status_out_one <= drv_open_drain[1] ? 1'b0 : status_value[1];
			status_out_one_oe <= done_r && !dec_active
				&& (!drv_open_drain[1] || !status_value[1]);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	// A one-cycle copy of the straps lets the capture check see the
	// very value that the capture edge took, independent of page_r.
	logic [2:0] cap_q;
	always_ff @(posedge clock or negedge reset_n)
	begin
		if (!reset_n)
			cap_q <= 3'h0;
		else
			cap_q <= strap_pins;
	end

	page_capture_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(done_r) |-> page_r == cap_q)
		else $error("ROM page does not match captured straps.");

	page_map_a: assert property (@(posedge clock) disable iff (!reset_n)
		$rose(config_done) |-> rom_page == $past(strap_pins))
		else $error("ROM page output differs from strap value.");

	page_default_a: assert property (@(posedge clock) disable iff (!reset_n)
		!done_r |-> rom_page == rpsc_pkg::PAGE_RESET)
		else $error("ROM page not at default before capture.");

	page_hold_a: assert property (@(posedge clock) disable iff (!reset_n)
		done_r |=> $stable(page_r) && done_r)
		else $error("ROM page changed after capture.");

	inc_role_a: assert property (@(posedge clock) disable iff (!reset_n)
		!done_r |=> !freq_increment_input)
		else $error("Increment active before reset completed.");

	dec_role_a: assert property (@(posedge clock) disable iff (!reset_n)
		dec_active |=> !status_out_one_oe)
		else $error("Status one driven while used as decrement.");

	addr_force_a: assert property (@(posedge clock) disable iff (!reset_n)
		startup_mode_select |=> i2c_target_addr[1:0] == 2'h0)
		else $error("I2C address low bits not forced to zero.");

	open_drain_a: assert property (@(posedge clock) disable iff (!reset_n)
		drv_open_drain[0] |=> !status_out_zero)
		else $error("Open-drain status zero drove high.");

	push_pull_a: assert property (@(posedge clock) disable iff (!reset_n)
		done_r && !drv_open_drain[1] && !dec_active
		|=> status_out_one_oe)
		else $error("Push-pull status one not driven.");

	inc_data_a: assert property (@(posedge clock) disable iff (!reset_n)
		done_r && controlled_osc_mode
		|=> freq_increment_input == $past(strap_pin_two))
		else $error("Increment does not follow strap pin two.");

	open_drain_one_a: assert property (@(posedge clock) disable iff (!reset_n)
		drv_open_drain[1] |=> !status_out_one)
		else $error("Open-drain status one drove high.");
endmodule

// ---- rpsc_board.sv ----
// Board model: strap resistors and the host that drives the oscillator
// steps. Assumes a pullup on each status pad.
module rpsc_board (
	input wire logic [2:0] straps,
	input wire logic dec_drive,
	input wire logic dec_level,
	input wire logic [1:0] pad_out,
	input wire logic [1:0] pad_oe,
	output logic [2:0] strap_pins,
	output logic [1:0] status_pin_in
);
	assign strap_pins = straps;
	assign status_pin_in[0] = pad_oe[0] ? pad_out[0] : 1'b1;
	assign status_pin_in[1] = dec_drive ? dec_level
		: (pad_oe[1] ? pad_out[1] : 1'b1);
endmodule

// ---- tb.sv ----
// Self-checking bench for the strap loader, one reset per ROM page.
// Assumes outputs follow inputs by one clock after capture.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0;
	logic reset_n = 1'b0;
	logic [2:0] straps = 3'h0;
	logic mode = 1'b1, osc = 1'b0, den = 1'b0, dlv = 1'b0;
	logic [1:0] od = 2'h0, sv = 2'h0;
	wire logic [1:0] so, soe, spi;
	logic [3:0] ps;
	logic [2:0] rom_page, sp;
	logic [6:0] addr;
	logic done, inc, dec, blk;
	int error_cnt = 0;
	int tests_run = 0;
	rpsc_strap_config i_rpsc_strap_config (.clock(clock),
		.reset_n(reset_n), .strap_pins(sp), .startup_mode_select(mode),
		.controlled_osc_mode(osc), .drv_open_drain(od),
		.decrement_enable(den), .status_value(sv), .status_pin_in(spi),
		.rom_page(rom_page), .config_done(done), .i2c_target_addr(addr),
		.freq_increment_input(inc), .freq_decrement_input(dec),
		.status_out_zero(so[0]), .status_out_zero_oe(soe[0]),
		.status_out_one(so[1]), .status_out_one_oe(soe[1]));
	rpsc_board i_rpsc_board (.straps(straps), .dec_drive(osc & den),
		.dec_level(dlv), .pad_out(so), .pad_oe(soe), .strap_pins(sp),
		.status_pin_in(spi));
	// Open drain only ever pulls low, so a high level releases the pad.
	function automatic logic [1:0] pad(input logic o, input logic v);
		return o ? {1'b0, ~v} : {v, 1'b1};
	endfunction
	task automatic check(input logic [6:0] seen, input logic [6:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("ERROR %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial
	begin
		forever #2 clock = ~clock;
	end
	initial
	begin
		#20000;
		error_cnt++;
		final_report();
	end
	initial
	begin
		void'($urandom(32'h987B28EE));
		for (int p = 0; p < 8; p++)
		begin
			@(negedge clock);
			reset_n = 1'b0;
			{straps, osc} = {3'(p), 1'b0};
			repeat (10) @(negedge clock);
			reset_n = 1'b1;
			for (int n = 0; n < 20 && done !== 1'b1; n++)
				@(negedge clock);
			check(7'(done), 7'h1);
			check(7'(rom_page), 7'(p));
			repeat (40)
			begin
				{straps, od, sv, osc, den, dlv, mode} = 11'($urandom);
				blk = osc & den;
				ps = {pad(od[1], sv[1]), pad(od[0], sv[0])};
				@(negedge clock);
				check(addr, 7'h64);
				check(7'(inc), 7'(straps[2] & osc));
				check(7'(dec), 7'(dlv & blk));
				check(7'({so[0], soe[0]}), 7'(ps[1:0]));
				check(7'(soe[1]), 7'(ps[2] & ~blk));
				if (!blk)
					check(7'(so[1]), 7'(ps[3]));
			end
			check(7'(rom_page), 7'(p));
		end
		final_report();
	end
endmodule
